// ===== dhif_frontend.v
`timescale 1ns/10ps
`include "dhif_consts.vh"
module dhif_frontend (
  input  wire                      clk,
  input  wire                      rst,
  input  wire                      ce,
  input  wire                      interface_select,
  input  wire                      chain_select,
  input  wire                      write_buffer_enable,
  input  wire                      frame_sync_n,
  input  wire                      serial_clk,
  input  wire                      serial_in,
  input  wire                      chip_select_n,
  input  wire                      write_strobe_n,
  input  wire [`DHIF_DATA_W-1:0]   parallel_data_bus,
  input  wire [`DHIF_GRP_W-1:0]    group_address_bits,
  input  wire [`DHIF_CH_W-1:0]     channel_address_bits,
  input  wire                      register_select_low,
  input  wire                      register_select_high,
  input  wire                      sink_ready,
  output reg                       serial_out,
  output reg                       chain_mode,
  output reg                       wr_valid,
  output reg  [`DHIF_GRP_W-1:0]    wr_group,
  output reg  [`DHIF_CH_W-1:0]     wr_channel,
  output reg  [`DHIF_DATA_W-1:0]   wr_data,
  output reg                       wr_to_data,
  output reg                       wr_to_gain,
  output reg                       wr_to_offset,
  output reg                       incdec_cmd,
  output reg                       soft_reset_pulse,
  output reg                       buf_full
);
  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // all pins are async to clk, two flops each before use
  localparam NSYNC = 9 + `DHIF_DATA_W + `DHIF_GRP_W + `DHIF_CH_W;
  wire [NSYNC-1:0] pin_raw;
  reg  [NSYNC-1:0] s1_reg;
  reg  [NSYNC-1:0] s2_reg;
  assign pin_raw = {interface_select, chain_select, write_buffer_enable, frame_sync_n,
                    serial_clk, serial_in, chip_select_n, write_strobe_n,
                    register_select_high, parallel_data_bus, group_address_bits,
                    channel_address_bits};
  // reset to each pin's idle level, so no false edge follows reset
  localparam [NSYNC-1:0] SYNC_IDLE = {3'h0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
                                      {(NSYNC-9){1'b0}}};
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_reg <= SYNC_IDLE;
      s2_reg <= SYNC_IDLE;
    end else if (ce) begin
      s1_reg <= pin_raw;
      s2_reg <= s1_reg;
    end
  end
  reg sel_low_s1_reg;
  reg sel_low_s2_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sel_low_s1_reg <= 1'b0;
      sel_low_s2_reg <= 1'b0;
    end else if (ce) begin
      sel_low_s1_reg <= register_select_low;
      sel_low_s2_reg <= sel_low_s1_reg;
    end
  end
  localparam P_CH  = 0;
  localparam P_GRP = `DHIF_CH_W;
  localparam P_DB  = P_GRP + `DHIF_GRP_W;
  localparam P_RS  = P_DB + `DHIF_DATA_W;
  wire                    ser_mode = s2_reg[P_RS+8];
  wire                    dc_pin   = s2_reg[P_RS+7];
  wire                    fifo_en  = s2_reg[P_RS+6];
  wire                    sync_n   = s2_reg[P_RS+5];
  wire                    sclk_s   = s2_reg[P_RS+4];
  wire                    din_s    = s2_reg[P_RS+3];
  wire                    cs_n_s   = s2_reg[P_RS+2];
  wire                    wr_n_s   = s2_reg[P_RS+1];
  wire [`DHIF_SEL_W-1:0]  rsel     = {s2_reg[P_RS], sel_low_s2_reg};
  wire [`DHIF_DATA_W-1:0] db_s     = s2_reg[P_RS-1:P_DB];
  wire [`DHIF_GRP_W-1:0]  grp_s    = s2_reg[P_DB-1:P_GRP];
  wire [`DHIF_CH_W-1:0]   ch_s     = s2_reg[P_GRP-1:P_CH];

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  reg sclk_d_reg;
  reg wr_n_d_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      sclk_d_reg <= 1'b1;
      wr_n_d_reg <= 1'b1;
    end else if (ce) begin
      sclk_d_reg <= sclk_s;
      wr_n_d_reg <= wr_n_s;
    end
  end
  wire sclk_fall = sclk_d_reg && !sclk_s;
  wire sclk_rise = !sclk_d_reg && sclk_s;
  // sampled with the same cycle as the strobe edge, so host setup covers both
  wire wr_rise   = !wr_n_d_reg && wr_n_s && !cs_n_s && !ser_mode;

  // ----------------------------------------
  // serial shift path
  // ----------------------------------------
  // only frames of at least word size commit (count holds at the word size); a short frame is dropped
  reg [`DHIF_SER_W-1:0]     shift_reg;
  reg [`DHIF_SER_CNT_W-1:0] bit_cnt_reg;
  reg                       ser_done_reg;
  reg                       sync_d_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_reg    <= `DHIF_WORD_RST;
      bit_cnt_reg  <= `DHIF_CNT_RST;
      ser_done_reg <= 1'b0;
      sync_d_reg   <= 1'b1;
      serial_out   <= 1'b0;
      chain_mode   <= 1'b0;
    end else if (ce) begin
      sync_d_reg   <= sync_n;
      ser_done_reg <= 1'b0;
      chain_mode   <= dc_pin && ser_mode;
      if (!ser_mode || sync_n) begin
        bit_cnt_reg <= `DHIF_CNT_RST;
      end else if (sclk_fall) begin
        shift_reg <= {shift_reg[`DHIF_SER_W-2:0], din_s};
        if (bit_cnt_reg != `DHIF_SER_W) begin
          bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end
      end
      // frame end: rising sync commits the last full word
      if (ser_mode && sync_n && !sync_d_reg && (bit_cnt_reg == `DHIF_SER_W)) begin
        ser_done_reg <= 1'b1;
      end
      if (sclk_rise && ser_mode) begin
        serial_out <= shift_reg[`DHIF_SER_W-1];
      end
    end
  end

  // ----------------------------------------
  // word assembly
  // ----------------------------------------
  reg                   in_valid_reg;
  reg [`DHIF_SER_W-1:0] in_word_reg;
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      in_valid_reg <= 1'b0;
      in_word_reg  <= `DHIF_WORD_RST;
    end else if (ce) begin
      in_valid_reg <= 1'b0;
      if (wr_rise) begin
        in_valid_reg <= 1'b1;
        in_word_reg  <= {grp_s, rsel, ch_s, db_s};
      end else if (ser_done_reg && !chain_mode) begin
        // in chain mode the word belongs to a device further along
        in_valid_reg <= 1'b1;
        in_word_reg  <= shift_reg;
      end
    end
  end

  // ----------------------------------------
  // write buffer
  // ----------------------------------------
  wire                   bq_valid;
  wire [`DHIF_SER_W-1:0] bq_word;
  wire                   bq_full;
  dhif_wbuf u_wbuf (
    .clk       (clk),
    .rst       (rst),
    .ce        (ce),
    .enable    (fifo_en),
    .in_valid  (in_valid_reg),
    .in_word   (in_word_reg),
    .out_ready (sink_ready),
    .out_valid (bq_valid),
    .out_word  (bq_word),
    .full      (bq_full)
  );

  // ----------------------------------------
  // destination decode
  // ----------------------------------------
  wire [`DHIF_SEL_W-1:0] q_sel = bq_word[`DHIF_SF_SEL_HI:`DHIF_SF_SEL_LO];
  wire [`DHIF_GRP_W-1:0] q_grp = bq_word[`DHIF_SF_GRP_HI:`DHIF_SF_GRP_LO];
  wire                   q_go  = bq_valid && (sink_ready || !fifo_en);
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_valid         <= 1'b0;
      wr_group         <= {`DHIF_GRP_W{1'b0}};
      wr_channel       <= {`DHIF_CH_W{1'b0}};
      wr_data          <= {`DHIF_DATA_W{1'b0}};
      wr_to_data       <= 1'b0;
      wr_to_gain       <= 1'b0;
      wr_to_offset     <= 1'b0;
      incdec_cmd       <= 1'b0;
      soft_reset_pulse <= 1'b0;
      buf_full         <= 1'b0;
    end else if (ce) begin
      buf_full         <= bq_full;
      wr_valid         <= 1'b0;
      wr_to_data       <= 1'b0;
      wr_to_gain       <= 1'b0;
      wr_to_offset     <= 1'b0;
      incdec_cmd       <= 1'b0;
      soft_reset_pulse <= 1'b0;
      if (q_go) begin
        wr_group   <= q_grp;
        wr_channel <= bq_word[`DHIF_SF_CH_HI:`DHIF_SF_CH_LO];
        wr_data    <= bq_word[`DHIF_SF_DAT_HI:`DHIF_SF_DAT_LO];
        if (q_sel == `DHIF_SEL_DATA) begin
          wr_valid   <= 1'b1;
          wr_to_data <= 1'b1;
        end else if (q_sel == `DHIF_SEL_GAIN) begin
          wr_valid   <= 1'b1;
          wr_to_gain <= 1'b1;
        end else if (q_sel == `DHIF_SEL_OFFSET) begin
          wr_valid     <= 1'b1;
          wr_to_offset <= 1'b1;
        end else if (q_grp == `DHIF_FN_SOFT_RST) begin
          soft_reset_pulse <= 1'b1;
        end else if (q_grp == `DHIF_FN_INCDEC) begin
          incdec_cmd <= 1'b1;
        end
      end
    end
  end
endmodule

// ===== dhif_consts.vh
`ifndef DHIF_CONSTS_VH
`define DHIF_CONSTS_VH
// ----------------------------------------
// widths
// ----------------------------------------
`define DHIF_DATA_W      14
`define DHIF_GRP_W       4
`define DHIF_CH_W        4
`define DHIF_SEL_W       2
// serial word: grp(4) + reg_sel(2) + ch(4) + data(14)
`define DHIF_SER_W       24
`define DHIF_SER_CNT_W   5
`define DHIF_FIFO_DEPTH  4
`define DHIF_FIFO_AW     2
`define DHIF_FIFO_CNT_W  3
// ----------------------------------------
// serial word field positions
// ----------------------------------------
`define DHIF_SF_GRP_HI   23
`define DHIF_SF_GRP_LO   20
`define DHIF_SF_SEL_HI   19
`define DHIF_SF_SEL_LO   18
`define DHIF_SF_CH_HI    17
`define DHIF_SF_CH_LO    14
`define DHIF_SF_DAT_HI   13
`define DHIF_SF_DAT_LO   0
// ----------------------------------------
// register select codes
// ----------------------------------------
`define DHIF_SEL_SPECIAL 2'h0
`define DHIF_SEL_GAIN    2'h1
`define DHIF_SEL_OFFSET  2'h2
`define DHIF_SEL_DATA    2'h3
// special function codes in group field
`define DHIF_FN_SOFT_RST 4'hF
`define DHIF_FN_INCDEC   4'hE
// ----------------------------------------
// reset values
// ----------------------------------------
`define DHIF_WORD_RST    24'h000000
`define DHIF_CNT_RST     5'h00
`define DHIF_SYNC_RST    2'h3
`define DHIF_SYNC_RST0   2'h0
`define DHIF_ONE_CNT     3'h1
`endif

// ===== dhif_wbuf.v
`timescale 1ns/10ps
`include "dhif_consts.vh"
module dhif_wbuf (
  input  wire                    clk,
  input  wire                    rst,
  input  wire                    ce,
  input  wire                    enable,
  input  wire                    in_valid,
  input  wire [`DHIF_SER_W-1:0]  in_word,
  input  wire                    out_ready,
  output reg                     out_valid,
  output reg  [`DHIF_SER_W-1:0]  out_word,
  output reg                     full
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  reg [`DHIF_SER_W-1:0]     mem_reg [0:`DHIF_FIFO_DEPTH-1];
  reg [`DHIF_FIFO_AW-1:0]   wr_ptr_reg;
  reg [`DHIF_FIFO_AW-1:0]   rd_ptr_reg;
  reg [`DHIF_FIFO_CNT_W-1:0] cnt_reg;
  wire                      push;
  wire                      pop;
  wire                      empty;
  integer                   i;

  assign empty = (cnt_reg == {`DHIF_FIFO_CNT_W{1'b0}});
  assign pop   = enable && !empty && (!out_valid || out_ready);
  assign push  = enable && in_valid && !full;

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_ptr_reg <= {`DHIF_FIFO_AW{1'b0}};
      rd_ptr_reg <= {`DHIF_FIFO_AW{1'b0}};
      cnt_reg    <= {`DHIF_FIFO_CNT_W{1'b0}};
      out_valid  <= 1'b0;
      out_word   <= `DHIF_WORD_RST;
      full       <= 1'b0;
      for (i = 0; i < `DHIF_FIFO_DEPTH; i = i + 1) begin
        mem_reg[i] <= `DHIF_WORD_RST;
      end
    end else if (ce) begin
      if (!enable) begin
        // bypass: one word passes straight through the output stage
        out_valid <= in_valid;
        out_word  <= in_word;
        full      <= 1'b0;
        cnt_reg   <= {`DHIF_FIFO_CNT_W{1'b0}};
      end else begin
        if (push) begin
          mem_reg[wr_ptr_reg] <= in_word;
          wr_ptr_reg <= wr_ptr_reg + 1'b1;
        end
        if (pop) begin
          out_word   <= mem_reg[rd_ptr_reg];
          rd_ptr_reg <= rd_ptr_reg + 1'b1;
          out_valid  <= 1'b1;
        end else if (out_ready) begin
          out_valid <= 1'b0;
        end
        if (push && !pop) begin
          cnt_reg <= cnt_reg + `DHIF_ONE_CNT;
          full    <= (cnt_reg == `DHIF_FIFO_DEPTH - 1);
        end else if (pop && !push) begin
          cnt_reg <= cnt_reg - `DHIF_ONE_CNT;
          full    <= 1'b0;
        end
      end
    end
  end
endmodule

// ===== dhif_monitor.sv
`timescale 1ns/10ps
`include "dhif_consts.vh"
module dhif_monitor (
  input logic        clk,
  input logic        rst,
  input logic        interface_select,
  input logic        chain_select,
  input logic        write_buffer_enable,
  input logic        serial_clk,
  input logic        chip_select_n,
  input logic        write_strobe_n,
  input logic [13:0] parallel_data_bus,
  input logic [3:0]  group_address_bits,
  input logic [3:0]  channel_address_bits,
  input logic        register_select_low,
  input logic        register_select_high,
  input logic        serial_out,
  input logic        chain_mode,
  input logic        wr_valid,
  input logic [3:0]  wr_group,
  input logic [3:0]  wr_channel,
  input logic [13:0] wr_data,
  input logic        wr_to_data,
  input logic        wr_to_gain,
  input logic        wr_to_offset,
  input logic        incdec_cmd,
  input logic        soft_reset_pulse
);
  // ----------------------------------------
  // parallel port
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // buffered writes leave at the sink's pace, so only the bypass path is timed
  sequence par_take(logic [1:0] code);
    $rose(write_strobe_n) && !chip_select_n && !interface_select && !write_buffer_enable
      && {register_select_high, register_select_low} == code;
  endsequence
  sequence par_refused;
    $rose(write_strobe_n) && (chip_select_n || interface_select)
      ##1 (chip_select_n || interface_select)[*3];
  endsequence
  property p_route(logic [1:0] code, logic hit);
    par_take(code) |-> ##[1:8] (wr_valid && hit && wr_data == parallel_data_bus
      && wr_group == group_address_bits && wr_channel == channel_address_bits);
  endproperty
  a_route_data: assert property (p_route(`DHIF_SEL_DATA, wr_to_data))
    else $error("data write not routed");
  a_route_gain: assert property (p_route(`DHIF_SEL_GAIN, wr_to_gain))
    else $error("gain write not routed");
  a_route_offset: assert property (p_route(`DHIF_SEL_OFFSET, wr_to_offset))
    else $error("offset write not routed");
  a_soft_reset: assert property (par_take(`DHIF_SEL_SPECIAL)
      ##0 group_address_bits == `DHIF_FN_SOFT_RST |-> ##[1:8] soft_reset_pulse)
    else $error("soft reset not issued");
  a_one_target: assert property (wr_valid |-> $onehot({wr_to_data, wr_to_gain, wr_to_offset}))
    else $error("write target not unique");
  a_strobe_ignored: assert property (par_refused
      |=> (!(wr_valid || incdec_cmd || soft_reset_pulse))[*6])
    else $error("refused strobe acted on");
  // ----------------------------------------
  // serial port
  // ----------------------------------------
  a_out_on_rise: assert property ((!serial_clk)[*4] |-> $stable(serial_out))
    else $error("serial output moved while clock low");
  a_chain_on: assert property ((chain_select && interface_select)[*4] |=> chain_mode)
    else $error("chain mode not entered");
  a_chain_off: assert property ((!chain_select || !interface_select)[*4] |=> !chain_mode)
    else $error("chain mode without request");
endmodule
bind dhif_frontend dhif_monitor mon (.*);

// ===== dhif_host_model.sv
`timescale 1ns/10ps
module dhif_host_model (
  output logic        frame_sync_n,
  output logic        serial_clk,
  output logic        serial_in,
  input  logic        serial_out,
  output logic [23:0] rx
);
  // ----------------------------------------
  // serial host, clock parked high between frames
  // ----------------------------------------
  initial begin
    frame_sync_n = 1'h1;
    serial_clk = 1'h1;
    serial_in = 1'h0;
  end
  // downstream receiver of the chain samples on falls
  always @(negedge serial_clk) rx <= {rx[22:0], serial_out};
  task automatic send(input logic [23:0] w, input int n);
    frame_sync_n = 1'h0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = w[i];
      #400 serial_clk = 1'h0;
      #400 serial_clk = 1'h1;
    end
    #400 frame_sync_n = 1'h1;
    serial_in = ~serial_in; // released line keeps no value
  endtask
endmodule

// ===== tb_top.sv
`timescale 1ns/10ps
module tb_top;
  logic        clk, rst, ce, interface_select, chain_select, write_buffer_enable;
  logic        frame_sync_n, serial_clk, serial_in, chip_select_n, write_strobe_n;
  logic        register_select_low, register_select_high, sink_ready, serial_out;
  logic        chain_mode, wr_valid, wr_to_data, wr_to_gain, wr_to_offset;
  logic        incdec_cmd, soft_reset_pulse, buf_full;
  logic [13:0] parallel_data_bus, wr_data;
  logic [3:0]  group_address_bits, channel_address_bits, wr_group, wr_channel;
  logic [23:0] rx, last_word;
  logic [4:0]  last_kind;
  int          pulses, mismatches, compares, cycles;
  localparam logic [23:0] route_words [5] = '{24'h5EA001, 24'h043FFF, 24'hABC000,
                                             24'hE00000, 24'hF00000};
  localparam logic [4:0]  route_kinds [5] = '{5'h10, 5'h08, 5'h04, 5'h02, 5'h01};
  dhif_frontend   dut (.*);
  dhif_host_model host (.*);
  // ----------------------------------------
  // clock, watchdog, write capture
  // ----------------------------------------
  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (wr_valid || incdec_cmd || soft_reset_pulse) begin
      pulses++;
      last_word <= {wr_group, 2'h0, wr_channel, wr_data};
      last_kind <= {wr_to_data, wr_to_gain, wr_to_offset, incdec_cmd, soft_reset_pulse};
    end
    if (cycles > 4000) begin
      mismatches++;
      summarize();
    end
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic summarize();
    if (mismatches == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task automatic par_write(input logic cs_n, input logic [23:0] w);
    {group_address_bits, register_select_high, register_select_low} = w[23:18];
    channel_address_bits = w[17:14];
    parallel_data_bus = w[13:0];
    chip_select_n = cs_n;
    write_strobe_n = 1'h0;
    step(4);
    write_strobe_n = 1'h1;
    step(11);
    chip_select_n = 1'h1;
    step(1);
  endtask
  // specials carry no payload, so only their kind is judged
  task automatic expect_write(input int p0, input logic [23:0] w, input logic [4:0] kind);
    chk_val(pulses - p0, 32'h1);
    chk_val({27'h0, last_kind}, {27'h0, kind});
    if (kind[4:2] != 3'h0) chk_val({8'h0, last_word}, {8'h0, w[23:20], 2'h0, w[17:0]});
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_routes();
    int p0;
    for (int i = 0; i < 5; i++) begin
      p0 = pulses;
      par_write(1'h0, route_words[i]);
      expect_write(p0, route_words[i], route_kinds[i]);
    end
  endtask
  task automatic t_refused();
    int p0;
    p0 = pulses;
    par_write(1'h1, 24'h5EA001);
    chk_val(pulses - p0, 32'h0);
    interface_select = 1'h1;
    step(4);
    par_write(1'h0, 24'h5EA001);
    chk_val(pulses - p0, 32'h0);
  endtask
  task automatic t_serial();
    int p0;
    p0 = pulses;
    host.send(24'h355234, 24);
    step(10);
    expect_write(p0, 24'h355234, 5'h08);
    p0 = pulses;
    host.send(24'h355234, 20);
    step(10);
    chk_val(pulses - p0, 32'h0);
  endtask
  task automatic t_chain();
    int p0;
    chain_select = 1'h1;
    step(6);
    chk_flag(chain_mode, 1'h1);
    p0 = pulses;
    host.send(24'hC3A5F0, 24);
    host.send(24'h0F0F0F, 24);
    step(10);
    chk_val(pulses - p0, 32'h0);
    chk_val({8'h0, rx}, 32'h00C3A5F0);
    interface_select = 1'h0;
    step(6);
    chk_flag(chain_mode, 1'h0);
    chain_select = 1'h0;
  endtask
  task automatic t_fifo();
    int p0;
    write_buffer_enable = 1'h1;
    step(4);
    p0 = pulses;
    for (int i = 0; i < 6; i++) par_write(1'h0, {20'h5C000, 4'(i)});
    chk_val(pulses - p0, 32'h0);
    chk_flag(buf_full, 1'h1);
    sink_ready = 1'h1;
    step(20);
    chk_val(pulses - p0, 32'h5);
    chk_val({8'h0, last_word}, 32'h00500004);
    chk_flag(buf_full, 1'h0);
    write_buffer_enable = 1'h0;
  endtask
  initial begin
    rst = 1'h1;
    ce = 1'h1;
    interface_select = 1'h0;
    chain_select = 1'h0;
    write_buffer_enable = 1'h0;
    sink_ready = 1'h0;
    chip_select_n = 1'h1;
    write_strobe_n = 1'h1;
    {parallel_data_bus, group_address_bits, channel_address_bits} = 22'h0;
    {register_select_high, register_select_low} = 2'h0;
    repeat (12) @(posedge clk);
    #5 rst = 1'h0;
    step(4);
    chk_val({1'h0, serial_out, chain_mode, wr_valid, wr_group, wr_channel, wr_data,
             wr_to_data, wr_to_gain, wr_to_offset, incdec_cmd, soft_reset_pulse,
             buf_full}, 32'h0);
    t_routes();
    t_refused();
    t_serial();
    t_chain();
    t_fifo();
    summarize();
  end
endmodule
